// ---- core/adc_bus_conversion_control.sv ----
// bus port, command decode and conversion sequencing of the converter
// assumes mclk_in is the master clock; host pins are asynchronous
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"
module adc_bus_conversion_control #(
  parameter logic [8:0] SAMPLE_LEN = `SAMPLE_CLOCKS,
  parameter logic [8:0] CONVERT_LEN = `CONVERT_CLOCKS
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input adc_ctrl_pkg::host_bus_t host_bus_in,
  input wire logic [5:0] dual_purpose_inputs_in,
  input wire logic compare_high_in,
  output adc_ctrl_pkg::host_drive_t host_data_lines_out,
  output logic [3:0] mux_select_out,
  output logic mux_enable_out,
  output logic sampling_out,
  output logic [7:0] ladder_tap_out,
  output logic conversion_busy_out
);
  import adc_ctrl_pkg::*;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [11:0] bus_sync;
  logic [5:0] port_sync;
  logic [0:0] cmp_sync;

  pin_sync #(.WIDTH(12)) bus_sync_i (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .pins_in(host_bus_in),
    .pins_out(bus_sync)
  );

  pin_sync #(.WIDTH(7)) port_sync_i (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .pins_in({compare_high_in, dual_purpose_inputs_in}),
    .pins_out({cmp_sync, port_sync})
  );

  host_bus_t bus;
  assign bus = bus_sync;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    conv_state_t phase;
    logic [8:0] count;
    logic start_convert_bit;
    logic [3:0] channel_code_field;
    logic result_valid;
    logic low_byte;
    logic [7:0] high_hold;
    logic clk_prev;
    logic cs_idle_seen;
    logic [7:0] out_data;
    logic out_drive;
  } ctrl_state_t;
  ctrl_state_t st;
  ctrl_state_t next_st;

  logic strobe;
  logic sar_begin;
  logic sar_abort;
  logic sar_done;
  logic [7:0] sar_trial;
  logic [7:0] sar_result;
  logic [15:0] result_word;
  logic [15:0] discrete_word;
  logic [15:0] read_word;

  // one transfer per rising edge of the bus clock while selected
  assign strobe = !bus.chip_select_n && bus.bus_clock && !st.clk_prev;

  assign result_word = {7'h00, st.result_valid, sar_result};
  assign discrete_word = {4'h0, st.channel_code_field, 2'h0, port_sync};
  assign read_word = bus.register_select ? discrete_word : result_word;

  // ---------------------------------------------------------------
  // channel decode
  // ---------------------------------------------------------------
  function automatic logic [3:0] mux_of(input logic [3:0] code);
    logic [3:0] sel;
    sel = `MUX_NONE;
    case (code)
      4'h0: sel = 4'h0;
      4'h1: sel = 4'h1;
      4'h2, 4'h3, 4'h4, 4'h5: sel = code;
      4'ha: sel = 4'ha;
      4'hb: sel = 4'hb;
      4'hc: sel = 4'h8;
      4'hd: sel = 4'h9;
      4'he: sel = 4'h6;
      4'hf: sel = 4'h7;
      default: sel = `MUX_NONE;
    endcase
    return sel;
  endfunction

  // ---------------------------------------------------------------
  // control
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    sar_begin = 1'b0;
    sar_abort = 1'b0;
    next_st.clk_prev = bus.bus_clock;
    next_st.out_drive = 1'b0;

    // counter back to high byte after chip select idle a full cycle
    if (bus.chip_select_n) begin
      next_st.cs_idle_seen = 1'b1;
      if (st.cs_idle_seen) begin
        next_st.low_byte = 1'b0;
      end
    end else begin
      next_st.cs_idle_seen = 1'b0;
    end

    if (strobe) begin
      next_st.low_byte = !st.low_byte;
      if (bus.read_not_write) begin
        next_st.out_drive = 1'b1;
        next_st.out_data = st.low_byte ? read_word[7:0] : read_word[15:8];
      end else if (!st.low_byte) begin
        next_st.high_hold = bus.data;
      end else if (bus.register_select) begin
        // full control word: decode both halves together
        next_st.channel_code_field = bus.data[`CHAN_MSB_POS:0];
        next_st.start_convert_bit = st.high_hold[`START_BIT_POS];
        next_st.result_valid = 1'b0;
      end
    end else if (bus.read_not_write && !bus.chip_select_n && st.out_drive) begin
      next_st.out_drive = 1'b1;
    end

    // a started cycle consumes the start bit; restart aborts the old one
    if (st.start_convert_bit) begin
      next_st.start_convert_bit = 1'b0;
      next_st.phase = sample_state;
      next_st.count = '0;
      sar_abort = 1'b1;
    end else begin
      case (st.phase)
        idle_state: begin
          next_st.count = '0;
        end
        sample_state: begin
          if (st.count == SAMPLE_LEN - 9'h001) begin
            next_st.phase = convert_state;
            next_st.count = '0;
            sar_begin = 1'b1;
          end else begin
            next_st.count = st.count + 9'h001;
          end
        end
        convert_state: begin
          next_st.count = st.count + 9'h001;
          if (sar_done) begin
            next_st.phase = idle_state;
            next_st.count = '0;
            next_st.result_valid = 1'b1;
          end
        end
        default: begin
          next_st.phase = idle_state;
        end
      endcase
    end

    if (!resetn_in) begin
      next_st.phase = idle_state;
      next_st.count = '0;
      next_st.start_convert_bit = 1'b0;
      next_st.channel_code_field = `CHAN_ZERO;
      next_st.result_valid = 1'b0;
      next_st.low_byte = 1'b0;
      next_st.high_hold = '0;
      next_st.clk_prev = 1'b0;
      next_st.cs_idle_seen = 1'b0;
      next_st.out_data = '0;
      next_st.out_drive = 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    st <= next_st;
  end

  // ---------------------------------------------------------------
  // approximation engine
  // ---------------------------------------------------------------
  // trial length is the conversion time spread over eight bits
  sar_engine #(.BITS(8), .TRIAL_LEN(CONVERT_LEN >> 3)) sar_i (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .begin_in(sar_begin),
    .abort_in(sar_abort),
    .compare_high_in(cmp_sync[0]),
    .trial_out(sar_trial),
    .done_out(sar_done),
    .result_out(sar_result)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign host_data_lines_out.data = st.out_data;
  assign host_data_lines_out.drive_n = !st.out_drive;
  assign mux_select_out = mux_of(st.channel_code_field);
  assign mux_enable_out = (st.phase != idle_state);
  assign sampling_out = (st.phase == sample_state);
  assign ladder_tap_out = (st.phase == convert_state) ? sar_trial : 8'h00;
  assign conversion_busy_out = (st.phase != idle_state);
endmodule // adc_bus_conversion_control

// ---- core/adc_ctrl_defines.svh ----
// constants for the bus-controlled converter control block
// assumes a single 100 MHz master clock; bus transfers are strobed by the synchronised bus clock
//
// Notes on behaviour
// - exactly three converter states: idle, sampling, converting
// - idle is left only on a start request
// - first 32 clocks after start acquire the channel
// - conversion takes 256 clocks, then updates result and returns idle
// - under reset outputs inactive, data lines floated, converter idle
// - reset leaves the converted-data register unchanged
// - reset clears start bit, selects channel zero, byte counter to high
// - start by full two-byte control write with start bit one
// - accepted start bit clears itself, then the cycle begins
// - result-valid flag sets once new result is in data register
// - result read keeps valid flag; control write or reset clears it
// - new start during conversion aborts and restarts acquisition
// - transfer only while chip select low and bus clock high
// - words move as two bytes, high byte first
// - single byte hits high byte; counter resets after idle chip select
// - decode: 00 idle write, 01 control write, 10 result, 11 inputs
// - channel code maps to mux selects; codes 6 to 9 undefined
// - result word holds valid flag and 8-bit value
// - discrete word holds channel code and six input levels
// - eight trials from the msb, keep bit when input is higher
// - final bits copied to a separate data register
// - data lines driven only while host reads
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH
`define SAMPLE_CLOCKS 9'h020
`define CONVERT_CLOCKS 9'h100
`define TRIAL_CLOCKS 9'h020
`define START_BIT_POS 0
`define CHAN_MSB_POS 3
`define FLAG_BIT_POS 0
`define CHAN_ZERO 4'h0
`define MUX_NONE 4'hf
`endif

// ---- core/adc_ctrl_pkg.sv ----
// types shared by the converter control block
// assumes the defines header is compiled alongside
package adc_ctrl_pkg;
  typedef enum logic [2:0] {
    idle_state = 3'b001,
    sample_state = 3'b010,
    convert_state = 3'b100
  } conv_state_t;

  typedef struct packed {
    logic chip_select_n;
    logic read_not_write;
    logic register_select;
    logic bus_clock;
    logic [7:0] data;
  } host_bus_t;

  typedef struct packed {
    logic [7:0] data;
    logic drive_n;
  } host_drive_t;
endpackage

// ---- core/pin_sync.sv ----
// two-flop synchroniser for a group of pin inputs
// assumes pins are asynchronous to mclk_in
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [WIDTH-1:0] pins_in,
  output logic [WIDTH-1:0] pins_out
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_t;
  sync_state_t st;
  sync_state_t next_st;

  always_comb begin
    next_st.first = pins_in;
    next_st.second = st.first;
    if (!resetn_in) begin
      next_st = '0;
    end
  end

  always_ff @(posedge mclk_in) begin
    st <= next_st;
  end

  assign pins_out = st.second;
endmodule // pin_sync

// ---- core/sar_engine.sv ----
// successive approximation register with a separate result latch
// assumes the comparator output is already synchronised
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"
module sar_engine #(
  parameter int BITS = 8,
  parameter logic [8:0] TRIAL_LEN = `TRIAL_CLOCKS
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic begin_in,
  input wire logic abort_in,
  input wire logic compare_high_in,
  output logic [BITS-1:0] trial_out,
  output logic done_out,
  output logic [BITS-1:0] result_out
);
  typedef struct packed {
    logic [BITS-1:0] latch;
    logic [BITS-1:0] post;
    logic [BITS-1:0] result;
    logic [8:0] tick;
    logic running;
  } sar_state_t;
  sar_state_t st;
  sar_state_t next_st;

  always_comb begin
    next_st = st;
    if (begin_in || abort_in) begin
      next_st.latch = '0;
      next_st.post = '0;
      next_st.post[BITS-1] = 1'b1;
      next_st.tick = '0;
      next_st.running = begin_in;
    end else if (st.running) begin
      if (st.tick == TRIAL_LEN - 9'h001) begin
        next_st.tick = '0;
        if (compare_high_in) begin
          next_st.latch = st.latch | st.post;
        end
        next_st.post = st.post >> 1;
        if (st.post[0]) begin
          next_st.running = 1'b0;
          next_st.result = compare_high_in ? (st.latch | st.post) : st.latch;
        end
      end else begin
        next_st.tick = st.tick + 9'h001;
      end
    end
    if (!resetn_in) begin
      next_st.latch = '0;
      next_st.post = '0;
      next_st.tick = '0;
      next_st.running = 1'b0; // result kept
    end
  end

  always_ff @(posedge mclk_in) begin
    st <= next_st;
  end

  assign trial_out = st.latch | st.post;
  // flags the finishing edge itself, so result and valid land together and no extra cycle is spent
  assign done_out = st.running && (st.tick == TRIAL_LEN - 9'h001) && st.post[0];
  assign result_out = st.result;
endmodule // sar_engine

// ---- tb/adc_ctrl_properties.sv ----
// port checker for the converter control block
// assumes the bench runs the sampling phase at 8 clocks
`timescale 1ns/1ps
module adc_ctrl_properties #(
  parameter logic [8:0] SAMPLE_LEN = 9'h008,
  parameter logic [8:0] CONVERT_LEN = 9'h040
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input adc_ctrl_pkg::host_bus_t host_bus_in,
  input adc_ctrl_pkg::host_drive_t host_data_lines_out,
  input wire logic [3:0] mux_select_out,
  input wire logic sampling_out,
  input wire logic [7:0] ladder_tap_out
);
  import adc_ctrl_pkg::*;
  // ----
  // helpers
  // ----
  logic [3:0] since_cs;
  logic [8:0] conv_cnt;
  function automatic logic [7:0] low_bit(input logic [7:0] v);
    return v & (~v + 8'h01);
  endfunction
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) since_cs <= 4'hf;
    else if (!host_bus_in.chip_select_n) since_cs <= 4'h0;
    else if (since_cs != 4'hf) since_cs <= since_cs + 4'h1;
    if (!resetn_in || ladder_tap_out == 8'h00) conv_cnt <= 9'h000;
    else conv_cnt <= conv_cnt + 9'h001;
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  reset_quiet_a:
  assert property (disable iff (1'b0) !resetn_in |=> host_data_lines_out.drive_n && !sampling_out
    && ladder_tap_out == 8'h00 && mux_select_out == 4'h0) else $error("outputs active under reset");
  sample_span_a:
  assert property ($rose(sampling_out) |-> sampling_out [*8] ##1 !sampling_out) else $error("bad sampling span");
  first_trial_a:
  assert property ($fell(sampling_out) |-> ##[0:2] ladder_tap_out == 8'h80) else $error("first trial not msb");
  trial_step_a:
  assert property (ladder_tap_out != 8'h00 && $past(ladder_tap_out) != 8'h00 && $changed(ladder_tap_out)
    |-> low_bit(ladder_tap_out) == (low_bit($past(ladder_tap_out)) >> 1)) else $error("trial bit skipped");
  start_cause_a:
  assert property ($rose(sampling_out) |-> since_cs < 4'h8) else $error("idle left without a write");
  conv_span_a:
  assert property (conv_cnt <= CONVERT_LEN) else $error("conversion ran too long");
  drive_read_a:
  assert property (!host_data_lines_out.drive_n |-> !$past(host_bus_in.chip_select_n, 3)
    && $past(host_bus_in.read_not_write, 3)) else $error("lines driven without a read");
  drive_release_a:
  assert property (host_bus_in.chip_select_n [*4] |-> host_data_lines_out.drive_n) else $error("lines not released");
  sample_tap_a:
  assert property (sampling_out |-> ladder_tap_out == 8'h00) else $error("tap active while sampling");
endmodule // adc_ctrl_properties

bind adc_bus_conversion_control adc_ctrl_properties #(.SAMPLE_LEN(SAMPLE_LEN), .CONVERT_LEN(CONVERT_LEN)) chk (
  .mclk_in(mclk_in), .resetn_in(resetn_in), .host_bus_in(host_bus_in), .host_data_lines_out(host_data_lines_out),
  .mux_select_out(mux_select_out), .sampling_out(sampling_out), .ladder_tap_out(ladder_tap_out));

// ---- tb/host_bus_model.sv ----
// host processor on the 8-bit bus, one bus clock per byte
// assumes tasks are entered just after a rising mclk edge
`timescale 1ns/1ps
module host_bus_model (
  input wire logic mclk_in,
  input adc_ctrl_pkg::host_drive_t host_data_lines_in,
  output adc_ctrl_pkg::host_bus_t host_bus_out,
  output logic rd_strobe_out,
  output logic [7:0] rd_byte_out
);
  import adc_ctrl_pkg::*;
  // ----
  // wire and transfers
  // ----
  logic wr_en = 1'b0;
  logic [7:0] wr_byte = 8'h00;
  initial begin
    host_bus_out = 12'h800;
    rd_strobe_out = 1'b0;
    rd_byte_out = 8'h00;
  end
  // a released line flips every cycle so stale data cannot pass for a read
  always @(posedge mclk_in) begin
    if (!host_data_lines_in.drive_n) host_bus_out.data <= host_data_lines_in.data;
    else if (wr_en) host_bus_out.data <= wr_byte;
    else host_bus_out.data <= ~host_bus_out.data;
  end
  task automatic xfer(input logic rnw, input logic rs, input logic [15:0] w, input int n);
    for (int b = 0; b < n; b++) begin
      host_bus_out.chip_select_n <= 1'b0;
      host_bus_out.read_not_write <= rnw;
      host_bus_out.register_select <= rs;
      wr_en <= !rnw;
      wr_byte <= (b == 0) ? w[15:8] : w[7:0];
      repeat (4) @(posedge mclk_in);
      host_bus_out.bus_clock <= 1'b1;
      repeat (5) @(posedge mclk_in);
      rd_byte_out <= host_bus_out.data;
      rd_strobe_out <= rnw;
      host_bus_out.bus_clock <= 1'b0;
      @(posedge mclk_in);
      rd_strobe_out <= 1'b0;
    end
    host_bus_out.chip_select_n <= 1'b1;
    wr_en <= 1'b0;
    repeat (8) @(posedge mclk_in);
  endtask
endmodule // host_bus_model

// ---- tb/adc_bus_conversion_control_tb.sv ----
// self-checking bench for the converter control block
// assumes the host model and the checker are compiled first
`timescale 1ns/1ps
module adc_bus_conversion_control_tb;
  import adc_ctrl_pkg::*;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [5:0] pins = 6'h00;
  logic [7:0] target = 8'h00;
  logic [7:0] held;
  host_bus_t bus;
  host_drive_t drive;
  logic [3:0] mux;
  logic [7:0] tap;
  logic [7:0] rd_byte;
  logic rd_strobe, sampling, busy, compare_high;
  logic mux_en;
  logic [7:0] exp_q[$];
  int error_cnt = 0;
  int num_checks = 0;
  logic [3:0] mux_map [16] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hf, 4'hf, 4'hf, 4'hf,
    4'ha, 4'hb, 4'h8, 4'h9, 4'h6, 4'h7};
  always #5 mclk_in = ~mclk_in;
  // input sits half a step above target, so the search lands on target
  assign compare_high = tap <= target;
  adc_bus_conversion_control #(.SAMPLE_LEN(9'h008), .CONVERT_LEN(9'h040)) uut (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .host_bus_in(bus), .dual_purpose_inputs_in(pins),
    .compare_high_in(compare_high), .host_data_lines_out(drive), .mux_select_out(mux),
    .mux_enable_out(mux_en), .sampling_out(sampling), .ladder_tap_out(tap), .conversion_busy_out(busy));
  host_bus_model host (.mclk_in(mclk_in), .host_data_lines_in(drive), .host_bus_out(bus),
    .rd_strobe_out(rd_strobe), .rd_byte_out(rd_byte));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expv);
    num_checks++;
    if (seen !== expv) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", name, expv, seen);
    end
  endtask
  task automatic results();
    if (exp_q.size() != 0) error_cnt++;
    if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic rd(input logic rs, input logic [15:0] e, input int n);
    exp_q.push_back(e[15:8]);
    if (n == 2) exp_q.push_back(e[7:0]);
    host.xfer(1'b1, rs, 16'h0000, n);
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge mclk_in);
      if (busy === 1'b0 && sampling === 1'b0) break;
    end
    if (i == 400) begin
      error_cnt++;
      results();
    end
  endtask
  always @(posedge mclk_in) begin
    if (rd_strobe === 1'b1) check("read byte", {8'h00, rd_byte}, {8'h00, exp_q.pop_front()});
  end
  // ----
  // stimulus
  // ----
  initial begin
    void'($urandom(32'h69b9e494));
    repeat (3) @(posedge mclk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    check("mux", {12'h000, mux}, 16'h0000);
    for (int c = 0; c < 16; c++) begin
      pins <= 6'($urandom);
      host.xfer(1'b0, 1'b1, {12'h000, 4'(c)}, 2);
      check("mux", {12'h000, mux}, {12'h000, mux_map[c]});
      check("sampling", {15'h0000, sampling}, 16'h0000);
      rd(1'b1, {4'h0, 4'(c), 2'b00, pins}, 2);
    end
    target <= 8'($urandom);
    host.xfer(1'b0, 1'b1, 16'h0102, 2);
    wait_idle();
    check("mux enable", {15'h0000, mux_en}, 16'h0000);
    rd(1'b0, {8'h01, target}, 2);
    rd(1'b0, 16'h0100, 1);
    rd(1'b0, {8'h01, target}, 2);
    host.xfer(1'b0, 1'b0, 16'h0102, 2);
    check("sampling", {15'h0000, sampling}, 16'h0000);
    rd(1'b0, {8'h01, target}, 2);
    host.xfer(1'b0, 1'b1, 16'h0107, 2);
    check("tap", {15'h0000, tap != 8'h00}, 16'h0001);
    check("mux enable", {15'h0000, mux_en}, 16'h0001);
    target <= 8'($urandom);
    host.xfer(1'b0, 1'b1, 16'h0103, 2);
    wait_idle();
    rd(1'b0, {8'h01, target}, 2);
    held = target;
    target <= ~target;
    host.xfer(1'b0, 1'b1, 16'h0105, 2);
    resetn_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    check("mux", {12'h000, mux}, 16'h0000);
    rd(1'b0, {8'h00, held}, 2);
    results();
  end
endmodule // adc_bus_conversion_control_tb
